// File: verilog/usb_pkg.sv
// Purpose: shared constants, types and helpers for the serial bridge
// Assumes: one 20 MHz reference clock, synchronous active-high reset
// Notes:   baud divisors are derived from the clock rate by function

package usb_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 20_000_000; // reference rate
   localparam int unsigned CLK_PERIOD_NS = 50;         // period in ns

   // ---------------------------------------------------------------
   // character framing and packets
   // ---------------------------------------------------------------
   localparam int unsigned DATA_BITS     = 8;   // data bits per char
   localparam int unsigned STOP_BITS     = 1;   // stop bits per char
   localparam int unsigned PKT_MAX_BYTES = 64;  // bytes per packet max
   localparam int unsigned IDLE_CHARS    = 3;   // idle chars to close
   localparam int unsigned FIFO_DEPTH    = 4;   // words per fifo, both ways
   localparam int unsigned SPI_HALF_NS   = 500; // least sck half period
   // least half period rounds up to whole cycles
   localparam int unsigned SPI_HALF_CYC  =
      (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0]  PKT_CNT_RST   = 7'h00; // count after reset
   localparam logic [3:0]  BAUD_SEL_RST  = 4'h6;  // 9600 after reset

   // ---------------------------------------------------------------
   // parity modes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE
   } usb_parity_type;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // clock cycles per bit, rounded to nearest
   function automatic logic [17:0] baud_div(input logic [3:0] sel,
                                            input int unsigned clk_hz);
      int unsigned rate;
      case (sel)
         4'h0:    rate = 150;
         4'h1:    rate = 300;
         4'h2:    rate = 600;
         4'h3:    rate = 1200;
         4'h4:    rate = 2400;
         4'h5:    rate = 4800;
         4'h6:    rate = 9600;
         4'h7:    rate = 19200;
         4'h8:    rate = 38400;
         4'h9:    rate = 57600;
         4'hA:    rate = 76800;
         4'hB:    rate = 115200;
         default: rate = 9600;   // unused codes fall back
      endcase
      return 18'((clk_hz + rate / 2) / rate);
   endfunction

   // bits on the wire per character: start, data, parity, stop
   function automatic logic [3:0] char_bits(input usb_parity_type p);
      return 4'(1 + DATA_BITS + STOP_BITS + ((p == PAR_NONE) ? 0 : 1));
   endfunction

   // parity bit value for a data byte
   function automatic logic par_bit(input usb_parity_type p,
                                    input logic [7:0] d);
      case (p)
         PAR_ODD:  return ~^d;
         PAR_EVEN: return ^d;
         PAR_MARK: return 1'b1;
         default:  return 1'b0;
      endcase
   endfunction

endpackage

// File: verilog/usb_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   ready and valid flags are registered for clean timing
`timescale 1ns/1ns

module usb_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("usb_fifo depth must be a power of two, at least 2");
   end

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];  // storage words
   logic [AW-1:0]    wr_q;           // write pointer
   logic [AW-1:0]    rd_q;           // read pointer
   logic [AW:0]      cnt_q;          // words held
   logic [AW:0]      cnt_d;          // next word count
   logic             push;           // accepted write
   logic             pop;            // accepted read

   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;
   assign out_data = mem_q[rd_q];

   // next count from push and pop
   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // storage write, no reset needed on data
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers, count and registered flags
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_q      <= '0;
         rd_q      <= '0;
         cnt_q     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_q      <= push ? wr_q + 1'b1 : wr_q;
         rd_q      <= pop ? rd_q + 1'b1 : rd_q;
         cnt_q     <= cnt_d;
         in_ready  <= (cnt_d != (AW+1)'(DEPTH));
         out_valid <= (cnt_d != '0);
      end
   end

   // never more words than slots
   AST_FIFO_BOUND: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cnt_q <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");

endmodule

// File: verilog/usb_bridge.sv
// Purpose: transparent host byte stream to UART or SPI bridge
// Assumes: inputs synchronous to ref_clk; host side is a byte stream
// Notes:   upstream bytes are grouped in packets flagged by up_last
// Function
// - host sees plain byte stream, serial port
// - SPI mode forwards bytes both ways, unframed
// - twelve selectable baud rates, 150 to 115200
// - 8 data, 1 stop, five parities, duplex
// - packets to host hold at most 64
// - packet closes after three idle character times
// - UART mode passes bytes unchanged both ways
// - programming pins: ss_n, sck, sdi, sdo, power
`timescale 1ns/1ns

module usb_bridge #(
   parameter int unsigned CLK_HZ = usb_pkg::CLK_HZ,
   parameter int unsigned DEPTH  = usb_pkg::FIFO_DEPTH
) (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       mode_spi,
   input  wire logic [3:0] baud_sel,
   input  wire logic [2:0] parity_sel,
   input  wire logic [7:0] dn_data,
   input  wire logic       dn_valid,
   output logic            dn_ready,
   output logic      [7:0] up_data_q,
   output logic            up_valid_q,
   output logic            up_last_q,
   input  wire logic       up_ready,
   output logic            uart_txd_q,
   input  wire logic       uart_rxd,
   output logic            pgm_ss_n_q,
   output logic            pgm_sck_q,
   output logic            pgm_sdo_q,
   input  wire logic       pgm_sdi,
   output logic            vout_en_q
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (CLK_HZ < 4_000_000) begin : g_chk
      $error("usb_bridge needs a clock of at least 4 MHz");
   end

   typedef enum {ST_IDLE, ST_UART, ST_SPI} usb_tx_state_type;

   usb_pkg::usb_parity_type par;       // selected parity
   logic [17:0]      div;              // cycles per bit
   logic [23:0]      idle_len;         // idle cycles to close
   logic [7:0]       fifo_data;        // downstream head word
   logic             fifo_valid;       // downstream word waiting
   logic             fifo_pop;         // take downstream word
   usb_tx_state_type st_q;             // downstream engine state
   logic [10:0]      tx_sh_q;          // uart frame shifter
   logic [3:0]       tx_bits_q;        // uart bits left
   logic [17:0]      tx_cnt_q;         // uart bit timer
   logic             rx_busy_q;        // uart frame in progress
   logic [17:0]      rx_cnt_q;         // uart sample timer
   logic [3:0]       rx_bit_q;         // uart bit index
   logic [7:0]       rx_sh_q;          // uart received data
   logic             rx_done;          // uart byte complete
   logic [7:0]       spi_sh_q;         // spi shifter
   logic [4:0]       spi_edge_q;       // spi edges left
   logic [7:0]       spi_half_q;       // spi half period timer
   logic             spi_done;         // spi byte complete
   logic             src_valid;        // new byte for host
   logic [7:0]       src_byte;         // that byte
   logic [7:0]       hold_q;           // last byte, not yet pushed
   logic             hold_valid_q;     // hold_q occupied
   logic [6:0]       pkt_cnt_q;        // bytes in open packet
   logic             force_q;          // flush full packet now
   logic [23:0]      idle_q;           // idle time counter
   logic [3:0]       baud_prev_q;      // settings last cycle
   logic [2:0]       par_prev_q;       // settings last cycle
   logic             expire;           // idle timeout hit
   logic             push_valid;       // write to upstream fifo
   logic [8:0]       push_data;        // {last, byte}
   logic             push_ready;       // upstream fifo room
   logic [8:0]       up_fifo_data;     // upstream head word
   logic             up_fifo_valid;    // upstream word waiting
   logic             up_take;          // load output stage

   // ---------------------------------------------------------------
   // line settings
   // ---------------------------------------------------------------
   assign par = usb_pkg::usb_parity_type'(parity_sel);
   assign div = usb_pkg::baud_div(baud_sel, CLK_HZ);
   // three characters of current framing
   assign idle_len = 24'(usb_pkg::IDLE_CHARS) *
                     24'(usb_pkg::char_bits(par)) * 24'(div);

   // ---------------------------------------------------------------
   // downstream buffer, host to module
   // ---------------------------------------------------------------
   // host stalls through dn_ready when the line is slower
   usb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_dn_fifo (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_data   (dn_data),
      .in_valid  (dn_valid),
      .in_ready  (dn_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   assign fifo_pop = (st_q == ST_IDLE) && fifo_valid;

   // downstream engine: one byte at a time, to uart or spi
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (fifo_valid) begin
                  st_q <= mode_spi ? ST_SPI : ST_UART;
               end
            end
            ST_UART: begin
               if (tx_bits_q == 4'h0) begin
                  st_q <= ST_IDLE;
               end
            end
            ST_SPI: begin
               if (spi_done) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // uart transmitter
   // ---------------------------------------------------------------
   // frame loaded whole, byte untouched
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_sh_q    <= 11'h7FF;
         tx_bits_q  <= 4'h0;
         tx_cnt_q   <= '0;
         uart_txd_q <= 1'b1;
      end else if (fifo_pop && !mode_spi) begin
         // start bit first, parity slot fills with stop when unused
         tx_sh_q    <= {1'b1, (par == usb_pkg::PAR_NONE) ? 1'b1 :
                        usb_pkg::par_bit(par, fifo_data), fifo_data, 1'b0};
         tx_bits_q  <= usb_pkg::char_bits(par);
         tx_cnt_q   <= '0;
         uart_txd_q <= 1'b1;
      end else if (tx_bits_q != 4'h0) begin
         if (tx_cnt_q == 18'h0_0000) begin
            uart_txd_q <= tx_sh_q[0];
            tx_sh_q    <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q   <= div - 1'b1;
         end else if (tx_cnt_q == 18'h0_0001) begin
            tx_bits_q  <= tx_bits_q - 1'b1;
            tx_cnt_q   <= '0;
         end else begin
            tx_cnt_q   <= tx_cnt_q - 1'b1;
         end
      end else begin
         uart_txd_q <= 1'b1;   // idle line stays marked
      end
   end

   // ---------------------------------------------------------------
   // uart receiver, runs beside the transmitter
   // ---------------------------------------------------------------
   // mid-bit sampling; parity and stop are read but not judged,
   // since the bridge never reports errors
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rx_busy_q <= 1'b0;
         rx_cnt_q  <= '0;
         rx_bit_q  <= 4'h0;
         rx_sh_q   <= 8'h00;
      end else if (!rx_busy_q) begin
         if (!uart_rxd && !mode_spi) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q  <= {1'b0, div[17:1]};
            rx_bit_q  <= 4'h0;
         end
      end else if (rx_cnt_q != 18'h0_0000) begin
         rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
         rx_cnt_q <= div - 1'b1;
         rx_bit_q <= rx_bit_q + 1'b1;
         if (rx_bit_q == 4'h0 && uart_rxd) begin
            rx_busy_q <= 1'b0;   // glitch, not a start bit
         end else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
            rx_sh_q <= {uart_rxd, rx_sh_q[7:1]};
         end
         if (rx_bit_q == usb_pkg::char_bits(par) - 4'h1) begin
            rx_busy_q <= 1'b0;
         end
      end
   end

   assign rx_done = rx_busy_q && (rx_cnt_q == 18'h0_0000) &&
                    (rx_bit_q == usb_pkg::char_bits(par) - 4'h1);

   // ---------------------------------------------------------------
   // spi master, mode 0, one byte per select
   // ---------------------------------------------------------------
   // full duplex shift, nothing added or stripped
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         spi_sh_q   <= 8'h00;
         spi_edge_q <= 5'h00;
         spi_half_q <= 8'h00;
         pgm_ss_n_q <= 1'b1;
         pgm_sck_q  <= 1'b0;
         pgm_sdo_q  <= 1'b0;
      end else if (fifo_pop && mode_spi) begin
         spi_sh_q   <= {fifo_data[6:0], 1'b0};
         pgm_sdo_q  <= fifo_data[7];
         pgm_ss_n_q <= 1'b0;
         spi_edge_q <= 5'h10;
         spi_half_q <= 8'(usb_pkg::SPI_HALF_CYC - 1);
      end else if (spi_edge_q != 5'h00) begin
         if (spi_half_q != 8'h00) begin
            spi_half_q <= spi_half_q - 1'b1;
         end else begin
            spi_half_q <= 8'(usb_pkg::SPI_HALF_CYC - 1);
            spi_edge_q <= spi_edge_q - 1'b1;
            pgm_sck_q  <= ~pgm_sck_q;
            if (!pgm_sck_q) begin
               spi_sh_q[0] <= pgm_sdi;        // sample on rise
            end else begin
               pgm_sdo_q <= spi_sh_q[7];      // shift on fall
               spi_sh_q  <= {spi_sh_q[6:0], 1'b0};
            end
            if (spi_edge_q == 5'h01) begin
               pgm_ss_n_q <= 1'b1;
            end
         end
      end
   end

   assign spi_done = (spi_edge_q == 5'h01) && (spi_half_q == 8'h00);

   // module power on except during reset; the bridge has no other power control
   always_ff @(posedge ref_clk) begin
      vout_en_q <= !sys_rst;
   end

   // ---------------------------------------------------------------
   // packet assembly toward the host
   // ---------------------------------------------------------------
   // one byte held back so the last of a packet can carry the flag
   assign src_valid = mode_spi ? spi_done : rx_done;
   assign src_byte  = mode_spi ? {spi_sh_q[7:1], pgm_sdi} : rx_sh_q;
   assign expire    = hold_valid_q && !src_valid && !force_q &&
                      (idle_q >= idle_len);

   // force first: full packet leaves without waiting
   always_comb begin
      push_valid = 1'b0;
      push_data  = {1'b0, hold_q};
      if (force_q) begin
         push_valid = 1'b1;
         push_data  = {1'b1, hold_q};
      end else if (src_valid && hold_valid_q) begin
         push_valid = 1'b1;       // byte as received
      end else if (expire) begin
         push_valid = 1'b1;
         push_data  = {1'b1, hold_q};
      end
   end

   // hold register and packet byte count
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hold_q       <= 8'h00;
         hold_valid_q <= 1'b0;
         pkt_cnt_q    <= usb_pkg::PKT_CNT_RST;
         force_q      <= 1'b0;
      end else begin
         force_q <= src_valid &&
                    (pkt_cnt_q == 7'(usb_pkg::PKT_MAX_BYTES - 1));
         if (src_valid) begin
            hold_q       <= src_byte;
            hold_valid_q <= 1'b1;
            pkt_cnt_q    <= pkt_cnt_q + 1'b1;
         end else if (force_q || expire) begin
            hold_valid_q <= 1'b0;
            pkt_cnt_q    <= usb_pkg::PKT_CNT_RST;
         end
      end
   end

   // idle timer restarts on each byte and on new settings
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         idle_q      <= '0;
         baud_prev_q <= usb_pkg::BAUD_SEL_RST;
         par_prev_q  <= 3'h0;
      end else begin
         baud_prev_q <= baud_sel;
         par_prev_q  <= parity_sel;
         if (src_valid || baud_sel != baud_prev_q ||
             parity_sel != par_prev_q) begin
            idle_q <= '0;
         end else if (hold_valid_q && idle_q != 24'hFF_FFFF) begin
            idle_q <= idle_q + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // upstream buffer and output stage
   // ---------------------------------------------------------------
   // the line cannot be stalled: a push into a full buffer is lost
   usb_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_up_fifo (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_data   (push_data),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .out_data  (up_fifo_data),
      .out_valid (up_fifo_valid),
      .out_ready (up_take)
   );

   assign up_take = !up_valid_q || up_ready;

   // registered byte stream to the host
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         up_data_q  <= 8'h00;
         up_valid_q <= 1'b0;
         up_last_q  <= 1'b0;
      end else if (up_take) begin
         up_data_q  <= up_fifo_data[7:0];
         up_valid_q <= up_fifo_valid;
         up_last_q  <= up_fifo_valid && up_fifo_data[8];
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_TX_IDLE: assert property (@(posedge ref_clk)
      disable iff (sys_rst) (st_q == ST_IDLE && tx_bits_q == 4'h0)
      |=> uart_txd_q) else $error("uart line not marked while idle");
   AST_TX_START: assert property (@(posedge ref_clk)
      disable iff (sys_rst) (fifo_pop && !mode_spi) |=> ##1 !uart_txd_q)
      else $error("uart start bit missing");
   AST_PKT_MAX: assert property (@(posedge ref_clk)
      disable iff (sys_rst) pkt_cnt_q <= 7'(usb_pkg::PKT_MAX_BYTES))
      else $error("packet grew past maximum");
   AST_FULL_FLUSH: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      (src_valid && pkt_cnt_q == 7'(usb_pkg::PKT_MAX_BYTES - 1))
      |=> push_valid && push_data[8])
      else $error("full packet not flushed at once");
   AST_IDLE_CLOSE: assert property (@(posedge ref_clk)
      disable iff (sys_rst) expire |-> push_data[8] ##1 !hold_valid_q)
      else $error("idle timeout did not close packet");
   AST_IDLE_RESTART: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      src_valid |=> idle_q == 24'h00_0000)
      else $error("idle timer not restarted");
   AST_PASS: assert property (@(posedge ref_clk)
      disable iff (sys_rst) (src_valid && hold_valid_q && !force_q)
      |-> push_data == {1'b0, hold_q})
      else $error("byte altered on the way up");
   AST_SPI_SEL: assert property (@(posedge ref_clk)
      disable iff (sys_rst) (spi_edge_q == 5'h00) |-> pgm_ss_n_q && !pgm_sck_q)
      else $error("spi select or clock active while idle");
   AST_SPI_BYTE: assert property (@(posedge ref_clk)
      disable iff (sys_rst) $fell(pgm_ss_n_q) |-> spi_edge_q == 5'h10)
      else $error("spi byte not eight clocks");

endmodule

// File: dv/usb_far.sv
// Purpose: far-side model: uart sender and spi mode 0 slave
// Assumes: the bench calls send just after a clock edge
// Notes:   a released sdi shows the inverse of its last bit
`timescale 1ns/1ns

module usb_far #(
   parameter int unsigned DIV   = 35,    // cycles per uart bit
   parameter logic [7:0]  REPLY = 8'hA5  // byte answered on spi
) (
   input  wire logic ref_clk,
   output logic      uart_rxd,
   input  wire logic pgm_ss_n_q,
   input  wire logic pgm_sck_q,
   input  wire logic pgm_sdo_q,
   output logic      pgm_sdi
);
   logic [7:0] got = 8'h00; // byte seen on sdo
   logic [7:0] sh;          // reply shifter
   initial uart_rxd = 1'b1;
   initial pgm_sdi = 1'b0;
   // 8 data lsb first, no parity, 1 stop
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         uart_rxd <= f[i];
         repeat (DIV) @(posedge ref_clk);
      end
   endtask
   // spi slave, msb first, sampled on rise
   always @(negedge pgm_ss_n_q) begin
      sh = REPLY;
      pgm_sdi = sh[7];
   end
   always @(posedge pgm_sck_q) got = {got[6:0], pgm_sdo_q};
   always @(negedge pgm_sck_q) begin
      sh = sh << 1;
      if (!pgm_ss_n_q) pgm_sdi = sh[7];
   end
   // released line must not keep its last value
   always @(posedge pgm_ss_n_q) pgm_sdi = ~pgm_sdi;
endmodule

// File: dv/usb_tb.sv
// Purpose: self-checking bench for the serial bridge
// Assumes: bridge built for a 4 MHz clock to shorten bit times
// Notes:   only the faster baud rates run, to keep the run short
`timescale 1ns/1ns

module testbench;
   localparam int unsigned CLK = 4_000_000;
   localparam int unsigned DIV = (CLK + 57_600) / 115_200;
   logic       ref_clk = 0, sys_rst = 1, mode_spi = 0, full_seen = 0;
   logic       dn_valid = 0, up_ready = 0;
   logic [3:0] baud_sel = 4'hB;
   logic [2:0] parity_sel = 3'h0;
   logic [7:0] dn_data = 8'h00;
   logic [7:0] up_data_q;
   logic       dn_ready, up_valid_q, up_last_q, uart_txd_q, uart_rxd;
   logic       pgm_ss_n_q, pgm_sck_q, pgm_sdo_q, pgm_sdi, vout_en_q;
   int         n_fail = 0, total_checks = 0, div = DIV;
   logic [8:0] upq[$]; // upstream words taken, {last, data}
   usb_bridge #(.CLK_HZ(CLK)) u_dut (.ref_clk, .sys_rst, .mode_spi,
      .baud_sel, .parity_sel, .dn_data, .dn_valid, .dn_ready, .up_data_q,
      .up_valid_q, .up_last_q, .up_ready, .uart_txd_q, .uart_rxd,
      .pgm_ss_n_q, .pgm_sck_q, .pgm_sdo_q, .pgm_sdi, .vout_en_q);
   usb_far #(.DIV(DIV)) u_far (.ref_clk, .uart_rxd, .pgm_ss_n_q,
      .pgm_sck_q, .pgm_sdo_q, .pgm_sdi);
   always #25 ref_clk = ~ref_clk;
   // collect upstream words on each accepting edge
   always @(posedge ref_clk)
      if (up_valid_q && up_ready) upq.push_back({up_last_q, up_data_q});
   task automatic final_report;
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask
   // a bounded wait ran out
   task automatic hang(string what);
      chk(what, 9'h000, 9'h1FF);
      final_report();
   endtask
   // hold a byte until the edge where it is taken
   task automatic put(logic [7:0] b);
      dn_data <= b;
      dn_valid <= 1'b1;
      for (int i = 0; i <= 9000; i++) begin
         @(posedge ref_clk);
         if (dn_ready === 1'b1) break;
         full_seen = 1'b1;
         if (i == 9000) hang("dn_ready");
      end
   endtask
   task automatic wait_q(int n, int lim);
      for (int i = 0; i <= lim && upq.size() < n; i++) begin
         @(posedge ref_clk);
         if (i == lim && upq.size() < n) hang("upstream");
      end
   endtask
   // decode one character: data, then {parity, stop}
   task automatic rx_char(output logic [7:0] d, output logic [1:0] ps);
      for (int i = 0; i <= 9000 && uart_txd_q !== 1'b0; i++) begin
         @(posedge ref_clk);
         if (i == 9000 && uart_txd_q !== 1'b0) hang("start bit");
      end
      repeat (div / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge ref_clk);
         d[i] = uart_txd_q;
      end
      ps = 2'b00;
      if (parity_sel != 3'h0) begin
         repeat (div) @(posedge ref_clk);
         ps[1] = uart_txd_q;
      end
      repeat (div) @(posedge ref_clk);
      ps[0] = uart_txd_q;
   endtask
   function automatic logic epar(logic [2:0] p, logic [7:0] d);
      case (p)
         3'h1: return ~^d;
         3'h2: return ^d;
         3'h3: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   // every parity mode, rates 4800 and up, one char each
   task automatic s_tx_parity;
      int rate[7] = '{4800, 9600, 19200, 38400, 57600, 76800, 115200};
      logic [7:0] d, e;
      logic [1:0] ps;
      for (int p = 0; p < 7; p++) begin
         e = 8'h3C ^ 8'(p);
         parity_sel <= 3'(p % 5);
         baud_sel <= 4'(5 + p);
         div = (CLK + rate[p] / 2) / rate[p];
         @(posedge ref_clk);
         put(e);
         dn_valid <= 1'b0;
         rx_char(d, ps);
         chk("tx data", 9'(e), 9'(d));
         chk("tx frame", 9'({epar(3'(p % 5), e), 1'b1}), 9'(ps));
      end
   endtask
   // six bytes back to back: fifo fills, host stalls, order kept
   task automatic s_tx_burst;
      logic [7:0] d;
      logic [1:0] ps;
      fork
         begin
            for (int i = 0; i < 6; i++) put(8'(8'hA0 + i));
            dn_valid <= 1'b0;
         end
         for (int i = 0; i < 6; i++) begin
            rx_char(d, ps);
            chk("burst data", 9'(8'hA0 + i), 9'(d));
         end
      join
      chk("fifo full", 9'h001, 9'(full_seen));
   endtask
   // two bytes, host stalled, packet closed by idle time
   task automatic s_rx_pkt;
      parity_sel <= 3'h0;
      u_far.send(8'h11);
      u_far.send(8'h22);
      repeat (20 * DIV) @(posedge ref_clk);
      chk("held word", 9'h111, {up_valid_q, up_data_q});
      up_ready <= 1'b1;
      repeat (8 * DIV) @(posedge ref_clk);
      chk("early close", 9'h001, 9'(upq.size()));
      wait_q(2, 4 * DIV);
      chk("pkt end", 9'h122, upq[1]);
      upq.delete();
   endtask
   // seventy bytes split after the 64th
   task automatic s_rx_64;
      for (int i = 0; i < 70; i++) u_far.send(8'(i));
      wait_q(70, 40 * DIV);
      for (int i = 0; i < 70; i++)
         chk("pkt byte", {i inside {63, 69}, 8'(i)}, upq[i]);
      upq.delete();
   endtask
   // spi passthrough: byte out on sdo, reply goes upstream
   task automatic s_spi;
      mode_spi <= 1'b1;
      @(posedge ref_clk);
      put(8'h5A);
      dn_valid <= 1'b0;
      wait_q(1, 60 * DIV);
      chk("spi out", 9'h05A, 9'(u_far.got));
      chk("spi in", 9'h1A5, upq[0]);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("idle pins", 9'h00D,
          9'({uart_txd_q, pgm_ss_n_q, pgm_sck_q, vout_en_q}));
      s_tx_parity();
      s_tx_burst();
      s_rx_pkt();
      s_rx_64();
      s_spi();
      final_report();
   end
endmodule
